// File: logic/clcf_pkg.sv
// Operation
// - Limit selector bits 26-22, speed/torque modes
// - Limit codes map 7.5 to 100 percent
// - Stop method bits 21-20: hi-z, spin, brake
// - Bit 19 enables overmodulation, reset off
// - Accel rate bits 18-14; bit 13 reuses it
// - Bits 13 and 3 clear select separate decel field
// - Mode field 29-28: speed, power, torque, voltage
// - Decel field used only without surge protection
package clcf_pkg;

    localparam logic [7:0] CLCF_OFS_SETTINGS = 8'h48;
    localparam logic [7:0] CLCF_OFS_STATUS = 8'h60;
    localparam logic [31:0] CLCF_SETTINGS_RST = 32'h0000_0000;
    localparam logic [31:0] CLCF_RO_MASK = 32'h0000_0004;

    localparam int CLCF_MODE_LSB = 28;
    localparam int CLCF_ILIM_LSB = 22;
    localparam int CLCF_STOP_LSB = 20;
    localparam int CLCF_OVM_BIT = 19;
    localparam int CLCF_ACC_LSB = 14;
    localparam int CLCF_DECSRC_BIT = 13;
    localparam int CLCF_DEC_LSB = 8;
    localparam int CLCF_AVS_BIT = 3;

    localparam logic [1:0] CLCF_MODE_SPEED = 2'h0;
    localparam logic [1:0] CLCF_MODE_POWER = 2'h1;
    localparam logic [1:0] CLCF_MODE_TORQUE = 2'h2;
    localparam logic [1:0] CLCF_MODE_VOLT = 2'h3;

    localparam logic [1:0] CLCF_STOP_HIZ = 2'h0;
    localparam logic [1:0] CLCF_STOP_SPIN = 2'h1;
    localparam logic [1:0] CLCF_STOP_BRAKE = 2'h2;
    localparam logic [1:0] CLCF_STOP_RSVD = 2'h3;

    localparam logic [4:0] CLCF_ILIM_RSVD_LO = 5'h1d;
    localparam logic [4:0] CLCF_ILIM_RSVD_HI = 5'h1e;
    localparam logic [4:0] CLCF_RATE_NOLIM = 5'h1f;

    // Limit in tenths of a percent of base current
    localparam logic [9:0] CLCF_LIMIT_TBL [32] = '{
        10'h04b, 10'h050, 10'h055, 10'h05a, 10'h05f, 10'h064, 10'h06e,
        10'h078, 10'h082, 10'h08c, 10'h096, 10'h0a0, 10'h0aa, 10'h0b4,
        10'h0c8, 10'h0e1, 10'h0fa, 10'h113, 10'h12c, 10'h15e, 10'h190,
        10'h1c2, 10'h1f4, 10'h226, 10'h258, 10'h2bc, 10'h2ee, 10'h320,
        10'h352, 10'h352, 10'h352, 10'h3e8
    };

    // Rate in units of 0.5 Hz/s; the last entry means no limit
    localparam logic [17:0] CLCF_RATE_TBL [32] = '{
        18'h00001, 18'h00002, 18'h00005, 18'h0000a, 18'h0000f,
        18'h00014, 18'h00028, 18'h00050, 18'h00078, 18'h000a0,
        18'h000c8, 18'h00190, 18'h00258, 18'h00320, 18'h003e8,
        18'h004b0, 18'h00578, 18'h00640, 18'h00708, 18'h007d0,
        18'h00fa0, 18'h01f40, 18'h02ee0, 18'h03e80, 18'h04e20,
        18'h09c40, 18'h0ea60, 18'h13880, 18'h186a0, 18'h1d4c0,
        18'h222e0, 18'h00000
    };

    typedef struct packed {
        logic [31:0] settings;
        logic [31:0] rdData;
        logic [9:0] limitPermille;
        logic limitActive;
        logic limitReserved;
        logic stopHiZ;
        logic stopSpinDown;
        logic stopBrake;
        logic stopReserved;
        logic overmodEn;
        logic [17:0] accelRate;
        logic accelNoLimit;
        logic [17:0] decelRate;
        logic decelNoLimit;
        logic decelFromAccel;
        logic decelSurgeOwned;
        logic updated;
    } clcf_state_s;

endpackage : clcf_pkg

// File: logic/clcf_rate_lut.sv
`timescale 1ns/1ps
module clcf_rate_lut
    import clcf_pkg::*;
(
    input wire logic [4:0] code,
    output logic [17:0] rate,
    output logic noLimit
);

    always_comb
    begin
        rate = CLCF_RATE_TBL[code];
        noLimit = (code == CLCF_RATE_NOLIM);
    end

endmodule : clcf_rate_lut

// File: logic/clcf_top.sv
`timescale 1ns/1ps
module clcf_top
    import clcf_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [31:0] rdData,
    output logic [1:0] controlMode,
    output logic [4:0] currentLimitSel,
    output logic [9:0] currentLimitPermille,
    output logic currentLimitActive,
    output logic currentLimitReserved,
    output logic stopHiZ,
    output logic stopSpinDown,
    output logic stopBrake,
    output logic stopReserved,
    output logic overmodEn,
    output logic [17:0] accelRate,
    output logic accelNoLimit,
    output logic [17:0] decelRate,
    output logic decelNoLimit,
    output logic decelFromAccel,
    output logic decelSurgeOwned,
    output logic settingsUpdated
);

    clcf_state_s state_r;
    clcf_state_s state_nxt;

    logic [31:0] settingsNext;
    logic [1:0] modeNext;
    logic [4:0] ilimNext;
    logic [1:0] stopNext;
    logic [4:0] accCode;
    logic [4:0] decCode;
    logic [17:0] accLutRate;
    logic accLutNoLim;
    logic [17:0] decLutRate;
    logic decLutNoLim;
    logic decSrcAccel;
    logic avsOn;
    logic [31:0] statusWord;

    // Decode from the value about to be stored so outputs follow a write
    // on the same edge that updates the register
    always_comb
    begin
        settingsNext = state_r.settings;
        if (wrEn && addr == CLCF_OFS_SETTINGS)
        begin
            settingsNext = wrData & ~CLCF_RO_MASK;
        end
    end

    assign modeNext = settingsNext[CLCF_MODE_LSB +: 2];
    assign ilimNext = settingsNext[CLCF_ILIM_LSB +: 5];
    assign stopNext = settingsNext[CLCF_STOP_LSB +: 2];
    assign accCode = settingsNext[CLCF_ACC_LSB +: 5];
    assign decSrcAccel = settingsNext[CLCF_DECSRC_BIT];
    assign avsOn = settingsNext[CLCF_AVS_BIT];
    assign decCode = settingsNext[CLCF_DEC_LSB +: 5];

    clcf_rate_lut accLut (
        .code(accCode),
        .rate(accLutRate),
        .noLimit(accLutNoLim)
    );

    clcf_rate_lut decLut (
        .code(decCode),
        .rate(decLutRate),
        .noLimit(decLutNoLim)
    );

    always_comb
    begin
        statusWord = 32'h0000_0000;
        statusWord[0] = state_r.limitActive;
        statusWord[1] = state_r.limitReserved;
        statusWord[2] = state_r.stopReserved;
        statusWord[3] = state_r.decelFromAccel;
        statusWord[4] = state_r.decelSurgeOwned;
        statusWord[5] = state_r.overmodEn;
        statusWord[6] = state_r.accelNoLimit;
        statusWord[7] = state_r.decelNoLimit;
        statusWord[25:16] = state_r.limitPermille;
    end

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.settings = settingsNext;
        state_nxt.updated = wrEn && addr == CLCF_OFS_SETTINGS;

        // Read data stand only in the cycle after the strobe
        state_nxt.rdData = 32'h0000_0000;
        if (rdEn)
        begin
            if (addr == CLCF_OFS_SETTINGS)
            begin
                state_nxt.rdData = state_r.settings;
            end
            else if (addr == CLCF_OFS_STATUS)
            begin
                state_nxt.rdData = statusWord;
            end
        end

        // Limit applies only where a current loop bounds torque
        state_nxt.limitActive = (modeNext == CLCF_MODE_SPEED) ||
            (modeNext == CLCF_MODE_TORQUE);
        state_nxt.limitPermille = CLCF_LIMIT_TBL[ilimNext];
        // Unlisted codes clamp to the highest listed value below full
        // scale rather than risk an unbounded current
        state_nxt.limitReserved = (ilimNext == CLCF_ILIM_RSVD_LO) ||
            (ilimNext == CLCF_ILIM_RSVD_HI);

        state_nxt.stopHiZ = 1'b0;
        state_nxt.stopSpinDown = 1'b0;
        state_nxt.stopBrake = 1'b0;
        state_nxt.stopReserved = 1'b0;
        unique case (stopNext)
            CLCF_STOP_HIZ: state_nxt.stopHiZ = 1'b1;
            CLCF_STOP_SPIN: state_nxt.stopSpinDown = 1'b1;
            CLCF_STOP_BRAKE: state_nxt.stopBrake = 1'b1;
            CLCF_STOP_RSVD:
            begin
                // Reserved code falls back to the safest stop
                state_nxt.stopHiZ = 1'b1;
                state_nxt.stopReserved = 1'b1;
            end
        endcase

        state_nxt.overmodEn = settingsNext[CLCF_OVM_BIT];

        state_nxt.accelRate = accLutRate;
        state_nxt.accelNoLimit = accLutNoLim;

        state_nxt.decelSurgeOwned = !decSrcAccel && avsOn;
        if (decSrcAccel || avsOn)
        begin
            // Bit 13 reuses the accel rate, or surge protection owns deceleration;
            // accel rate is reported as the nominal figure
            state_nxt.decelFromAccel = 1'b1;
            state_nxt.decelRate = accLutRate;
            state_nxt.decelNoLimit = accLutNoLim;
        end
        else
        begin
            state_nxt.decelFromAccel = 1'b0;
            state_nxt.decelRate = decLutRate;
            state_nxt.decelNoLimit = decLutNoLim;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= '0;
            state_r.settings <= CLCF_SETTINGS_RST;
            state_r.limitActive <= 1'b1;
            state_r.limitPermille <= CLCF_LIMIT_TBL[0];
            state_r.stopHiZ <= 1'b1;
            state_r.accelRate <= CLCF_RATE_TBL[0];
            state_r.decelRate <= CLCF_RATE_TBL[0];
        end
        else if (ce)
        begin
            state_r <= state_nxt;
        end
    end

    assign rdData = state_r.rdData;
    assign controlMode = state_r.settings[CLCF_MODE_LSB +: 2];
    assign currentLimitSel = state_r.settings[CLCF_ILIM_LSB +: 5];
    assign currentLimitPermille = state_r.limitPermille;
    assign currentLimitActive = state_r.limitActive;
    assign currentLimitReserved = state_r.limitReserved;
    assign stopHiZ = state_r.stopHiZ;
    assign stopSpinDown = state_r.stopSpinDown;
    assign stopBrake = state_r.stopBrake;
    assign stopReserved = state_r.stopReserved;
    assign overmodEn = state_r.overmodEn;
    assign accelRate = state_r.accelRate;
    assign accelNoLimit = state_r.accelNoLimit;
    assign decelRate = state_r.decelRate;
    assign decelNoLimit = state_r.decelNoLimit;
    assign decelFromAccel = state_r.decelFromAccel;
    assign decelSurgeOwned = state_r.decelSurgeOwned;
    assign settingsUpdated = state_r.updated;

endmodule : clcf_top

// File: bench/clcf_checker.sv
`timescale 1ns/1ps
module clcf_checker
    import clcf_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [31:0] rdData,
    input wire logic [1:0] controlMode,
    input wire logic [4:0] currentLimitSel,
    input wire logic currentLimitActive,
    input wire logic stopHiZ,
    input wire logic stopBrake,
    input wire logic overmodEn,
    input wire logic accelNoLimit,
    input wire logic decelFromAccel,
    input wire logic settingsUpdated
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic wr;
    assign wr = ce && wrEn && addr == CLCF_OFS_SETTINGS;
    a_limit_field: assert property (wr |=>
        currentLimitSel == $past(wrData[26:22])) else $error("limit code lost");
    a_stop_code: assert property (wr |=>
        stopBrake == ($past(wrData[21:20]) == 2'h2)
        && stopHiZ == ($past(wrData[21]) == $past(wrData[20])))
        else $error("stop method wrong");
    a_overmod_bit: assert property (wr |=>
        overmodEn == $past(wrData[19])) else $error("overmod wrong");
    a_accel_nolim: assert property (wr |=>
        accelNoLimit == (&$past(wrData[18:14]))) else $error("no limit wrong");
    a_decel_src: assert property (wr |=>
        decelFromAccel == ($past(wrData[13]) || $past(wrData[3])))
        else $error("decel source wrong");
    a_limit_mode: assert property (
        currentLimitActive == !controlMode[0]) else $error("limit mode wrong");
    a_read_idle: assert property (ce && !rdEn |=> rdData == 32'h0)
        else $error("read data outside slot");
    a_read_back: assert property (ce && rdEn && addr == CLCF_OFS_SETTINGS |=>
        rdData[26:22] == currentLimitSel && !rdData[2])
        else $error("read back wrong");
    a_update_pulse: assert property (wr |=> settingsUpdated)
        else $error("update pulse missing");
    // A low enable freezes the pulse, so only enabled idle edges count
    a_no_update: assert property (ce && !wr |=> !settingsUpdated)
        else $error("spurious update pulse");
endmodule : clcf_checker

bind clcf_top clcf_checker u_clcf_checker (.*);

// File: bench/clcf_top_tb.sv
`timescale 1ns/1ps
module clcf_top_tb;
    import clcf_pkg::*;
    localparam int LIM [32] = '{75, 80, 85, 90, 95, 100, 110, 120, 130, 140,
        150, 160, 170, 180, 200, 225, 250, 275, 300, 350, 400, 450, 500, 550,
        600, 700, 750, 800, 850, 850, 850, 1000};
    localparam int RATE [32] = '{1, 2, 5, 10, 15, 20, 40, 80, 120, 160, 200,
        400, 600, 800, 1000, 1200, 1400, 1600, 1800, 2000, 4000, 8000, 12000,
        16000, 20000, 40000, 60000, 80000, 100000, 120000, 140000, 0};
    logic clk, reset, ce, wrEn, rdEn;
    logic [7:0] addr;
    logic [31:0] wrData, rdData;
    logic [1:0] controlMode;
    logic [4:0] currentLimitSel;
    logic [9:0] currentLimitPermille;
    logic [17:0] accelRate, decelRate;
    logic currentLimitActive, currentLimitReserved, stopHiZ, stopSpinDown;
    logic stopBrake, stopReserved, overmodEn, accelNoLimit, decelNoLimit;
    logic decelFromAccel, decelSurgeOwned, settingsUpdated;
    int nErrors = 0;
    int nChecks = 0;

    clcf_top u_clcf_top (.*);

    task automatic end_of_test();
        $display("checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic cmp(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        nChecks++;
        if (g !== e)
        begin
            nErrors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // Strobe is held over exactly one sampling edge, then checks land after it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        cmp("rdData", e, rdData);
    endtask : rd

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        logic [31:0] v;
        reset = 1'b1;
        ce = 1'b1;
        wrEn = 1'b0;
        rdEn = 1'b0;
        addr = 8'h00;
        wrData = 32'h0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(CLCF_OFS_SETTINGS, 32'h0);
        cmp("permille", 75, currentLimitPermille);
        cmp("stopHiZ", 1, stopHiZ);
        cmp("overmodEn", 0, overmodEn);
        cmp("decelFromAccel", 0, decelFromAccel);
        for (int i = 0; i < 32; i++)
        begin
            wr(CLCF_OFS_SETTINGS, 32'(i) << 22 | 32'h2000_0000);
            cmp("limitSel", i, currentLimitSel);
            cmp("permille", LIM[i], currentLimitPermille);
            cmp("limitRsvd", i == 29 || i == 30, currentLimitReserved);
            wr(CLCF_OFS_SETTINGS, 32'(i) << 14 | 32'h2000);
            cmp("accelRate", RATE[i], accelRate);
            cmp("decelRate", RATE[i], decelRate);
            cmp("accelNoLimit", i == 31, accelNoLimit);
            cmp("decelNoLimit", i == 31, decelNoLimit);
        end
        for (int m = 0; m < 4; m++)
        begin
            v = 32'(m) << 28 | 32'(m) << 20 | 32'(m & 1) << 19;
            wr(CLCF_OFS_SETTINGS, v);
            cmp("controlMode", m, controlMode);
            cmp("limitActive", m == 0 || m == 2, currentLimitActive);
            cmp("stopHiZ", m == 0 || m == 3, stopHiZ);
            cmp("stopSpinDown", m == 1, stopSpinDown);
            cmp("stopBrake", m == 2, stopBrake);
            cmp("stopReserved", m == 3, stopReserved);
            cmp("overmodEn", m & 1, overmodEn);
            rd(CLCF_OFS_SETTINGS, v);
        end
        wr(CLCF_OFS_SETTINGS, 32'h0001_4300);
        cmp("decelRate", 10, decelRate);
        cmp("decelFromAccel", 0, decelFromAccel);
        cmp("decelSurgeOwned", 0, decelSurgeOwned);
        wr(CLCF_OFS_SETTINGS, 32'h0001_4308);
        cmp("decelRate", 20, decelRate);
        cmp("decelSurgeOwned", 1, decelSurgeOwned);
        rd(CLCF_OFS_STATUS, 32'h004b_0019);
        wr(CLCF_OFS_SETTINGS, 32'hffff_ffff);
        rd(CLCF_OFS_SETTINGS, 32'hffff_fffb);
        rd(CLCF_OFS_STATUS, 32'h03e8_00ec);
        wr(8'h10, 32'h0);
        rd(CLCF_OFS_SETTINGS, 32'hffff_fffb);
        rd(8'h10, 32'h0);
        // With the enable low the write must be lost
        @(posedge clk);
        ce <= 1'b0;
        wr(CLCF_OFS_SETTINGS, 32'h0);
        cmp("overmodEn", 1, overmodEn);
        @(posedge clk);
        ce <= 1'b1;
        end_of_test();
    end
endmodule : clcf_top_tb
